// ---- dv/host_mem_model.sv ----
// host memory seen over the block's dma port: answers after lat_i idle cycles
// assumes dma requests are held until acknowledged and change only after the ack edge
`timescale 1ns/10ps
`default_nettype none
module host_mem_model
  import fdc_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dma_req_t dma_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  // ----------------------------------------
  // memory and acknowledge
  // ----------------------------------------
  logic [7:0] mem [0:1023];
  logic [3:0] cnt;

  // read data toggle outside the ack cycle so stale data never looks valid
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= 8'h5a;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= ~rdata_o;
    end else if (dma_i.req && cnt >= lat_i) begin
      ack_o <= 1'b1;
      if (dma_i.we)
        mem[dma_i.addr[9:0]] <= dma_i.wdata;
      else
        rdata_o <= mem[dma_i.addr[9:0]];
    end else begin
      cnt <= dma_i.req ? cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the floppy host command block
// assumes the map header on the include path and the host memory model beside it
`timescale 1ns/10ps
`default_nettype none
`include "fdc_host_map.svh"
module testbench
  import fdc_host_pkg::*;
;
  localparam logic [7:0] PORT = 8'hfd;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, io_wr_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00, io_data_i = 8'h00, reg_wdata_i = 8'h00;
  logic [5:0] reg_addr_i = 6'h00;
  logic exec_done_i = 1'b0, exec_err_i = 1'b0, drive_ready_i = 1'b1, index_i = 1'b0;
  logic [3:0] lat = 4'h0;
  logic port_wait_o, port_ready_o, dma_ack_i, restore_o, irq_o, inv_irq;
  logic [7:0] reg_rdata_o, dma_rdata_i;
  logic [1:0] head_state_o;
  dma_req_t dma_o;
  exec_cmd_t exec_o;
  int err_total = 0, checks_done = 0, cyc = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  floppy_host_command_interface #(.PORT_ADDR(PORT)) dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .io_wr_i(io_wr_i), .io_addr_i(io_addr_i), .io_data_i(io_data_i), .port_wait_o(port_wait_o),
    .port_ready_o(port_ready_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dma_o(dma_o), .dma_ack_i(dma_ack_i),
    .dma_rdata_i(dma_rdata_i), .exec_o(exec_o), .exec_done_i(exec_done_i), .exec_err_i(exec_err_i),
    .drive_ready_i(drive_ready_i), .index_i(index_i), .restore_o(restore_o),
    .head_state_o(head_state_o), .irq_o(irq_o));
  host_mem_model mem_u (.clk_i(sys_clk_i), .reset_i(reset_i), .dma_i(dma_o), .lat_i(lat),
    .ack_o(dma_ack_i), .rdata_o(dma_rdata_i));
  // second copy strapped for the inverting board; its port address is never written, so it stays idle
  floppy_host_command_interface #(.PORT_ADDR(8'h00), .IRQ_INVERT(1'b1)) inv_u (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i), .io_data_i(io_data_i), .port_wait_o(),
    .port_ready_o(), .reg_addr_i(6'h00), .reg_wdata_i(8'h00), .reg_wr_i(1'b0), .reg_rd_i(1'b0),
    .reg_rdata_o(), .dma_o(), .dma_ack_i(1'b0), .dma_rdata_i(8'h00), .exec_o(), .exec_done_i(1'b0),
    .exec_err_i(1'b0), .drive_ready_i(drive_ready_i), .index_i(index_i), .restore_o(), .head_state_o(),
    .irq_o(inv_irq));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic hit(input int s);
    case (s)
      0: return exec_o.start;
      1: return irq_o;
      2: return port_ready_o;
      3: return restore_o;
      default: return head_state_o == `HEAD_RAISED;
    endcase
  endfunction
  // bounded wait, called a little after an edge
  task automatic wt(input int s);
    int n;
    n = 0;
    while (hit(s) !== 1'b1 && n < 500) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(hit(s), 16'h1, "wait expired");
  endtask
  task automatic rw(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rr(input logic [5:0] a, input logic [7:0] e, input string m);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e, m);
  endtask
  task automatic pw(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_addr_i <= a;
    io_data_i <= d;
    io_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    io_wr_i <= 1'b0;
    #1;
  endtask
  task automatic pulse(input bit e);
    @(posedge sys_clk_i);
    exec_err_i <= e;
    exec_done_i <= ~e;
    @(posedge sys_clk_i);
    exec_err_i <= 1'b0;
    exec_done_i <= 1'b0;
    #1;
  endtask
  task automatic run_str(input logic [3:0] e, input logic [9:0] b, input logic [7:0] fn, t, s);
    mem_u.mem[b] = fn;
    mem_u.mem[b+1] = 8'h00;
    mem_u.mem[b+2] = t;
    mem_u.mem[b+3] = s;
    mem_u.mem[b+4] = 8'h34;
    mem_u.mem[b+5] = 8'h12;
    pw(PORT, {`CMD_STRING, e});
  endtask
  task automatic clr_irq();
    pw(PORT, 8'hee);
    wt(2);
    chk(irq_o, 1'b0, "irq not cleared");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    chk({irq_o, inv_irq}, 2'h1, "irq polarity");
    rr(6'h05, 8'h01, "table hi");
    rr(6'h04, 8'h20, "table lo");
    rr(`REG_STATE, 8'h08, "state idle");
    rw(`REG_RETRY, 8'hff);
    rr(`REG_RETRY, 8'h00, "retry ro");
    rr(6'h3f, 8'h00, "unmapped");
    rw(`REG_CTRL, 8'h01);
    rr(`REG_CTRL, 8'h01, "wait flag");
    rw(`REG_CTRL, 8'h00);
    rw(6'h02, 8'h00);
    rw(6'h03, 8'h02);
    rr(6'h03, 8'h02, "table write");
  endtask
  task automatic t_noop();
    pw(8'hfc, 8'h10);
    chk(port_wait_o, 1'b0, "foreign port");
    pw(PORT, 8'hee);
    chk(port_wait_o, 1'b1, "no wait");
    wt(2);
    chk(dma_o.req, 1'b0, "noop moved");
  endtask
  // slow memory, physical track flag set, top sector
  task automatic t_ok();
    lat = 4'h3;
    run_str(4'h1, 10'h200, 8'h82, 8'h05, `SLOT_MAX);
    wt(0);
    chk(exec_o.op, 4'h2, "op");
    chk(exec_o.sector, `SLOT_MAX, "sector");
    chk(exec_o.track, 8'h05, "physical track");
    chk(exec_o.xfer_ptr, 16'h1234, "xfer ptr");
    chk(head_state_o, `HEAD_LOWERED, "head down");
    pulse(1'b0);
    wt(1);
    chk(mem_u.mem[10'h201], `STAT_OK, "status ok");
    chk(head_state_o, `HEAD_LIFT_PEND, "head pend");
    rr(`REG_OPCODE, 8'h20, "op reg");
    rr(`REG_PHYSICAL_TRACK, 8'h05, "physical track reg");
    @(posedge sys_clk_i);
    index_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    index_i <= 1'b0;
    #1;
    wt(4);
    clr_irq();
    lat = 4'h0;
  endtask
  // eleven attempts, then a final error
  task automatic t_retry();
    rw(`REG_TRK_SKIP, 8'h03);
    run_str(4'h2, 10'h120, 8'h01, 8'h04, 8'h01);
    for (int k = 0; k < 11; k++) begin
      wt(0);
      pulse(1'b1);
    end
    wt(1);
    chk(mem_u.mem[10'h121], `STAT_ERR, "retry status");
    rr(`REG_RETRY, 8'h0a, "retry count");
    chk(exec_o.track, 8'h07, "skipped track");
    rr(`REG_PHYSICAL_TRACK, 8'h07, "skipped track reg");
    rr(`REG_LOGICAL_TRACK, 8'h04, "logical track reg");
    rw(`REG_TRK_SKIP, 8'h00);
    clr_irq();
  endtask
  // flag set: a drive drop only stalls the operation; flag clear: the drop is fatal
  task automatic t_notready();
    rw(`REG_CTRL, 8'h01);
    run_str(4'h3, 10'h130, 8'h00, 8'h01, 8'h01);
    wt(0);
    @(posedge sys_clk_i);
    drive_ready_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    pulse(1'b0);
    chk(port_ready_o, 1'b0, "stall ended early");
    @(posedge sys_clk_i);
    drive_ready_i <= 1'b1;
    #1;
    wt(3);
    pulse(1'b0);
    wt(1);
    chk(mem_u.mem[10'h131], `STAT_OK, "stall then done");
    rw(`REG_CTRL, 8'h00);
    clr_irq();
    run_str(4'h3, 10'h130, 8'h00, 8'h01, 8'h01);
    wt(0);
    @(posedge sys_clk_i);
    drive_ready_i <= 1'b0;
    #1;
    wt(1);
    chk(mem_u.mem[10'h131], `STAT_NOTRDY, "not ready");
    @(posedge sys_clk_i);
    drive_ready_i <= 1'b1;
    #1;
    wt(3);
    clr_irq();
  endtask
  // sector zero, then an operation code beyond range
  task automatic t_bad();
    for (int k = 0; k < 2; k++) begin
      run_str(4'h3, 10'h130, k ? 8'h06 : 8'h03, 8'h00, k ? 8'h01 : 8'h00);
      wt(1);
      chk(mem_u.mem[10'h131], `STAT_BADPARAM, "bad param");
      clr_irq();
    end
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    t_regs();
    t_noop();
    t_ok();
    t_retry();
    t_notready();
    t_bad();
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- hdl/fdc_host_map.svh ----
// offsets, field positions, reset values and counts of the floppy host command block
// assumes inclusion by bare name from the testbench and the design file
`ifndef FDC_HOST_MAP_SVH
`define FDC_HOST_MAP_SVH
// register port offsets (byte wide, byte index)
`define REG_TAB_LAST    6'h1f
`define REG_CTRL        6'h20
`define REG_TRK_SKIP    6'h21
`define REG_STATE       6'h22
`define REG_RETRY       6'h23
`define REG_PHYSICAL_TRACK 6'h24
`define REG_LOGICAL_TRACK 6'h25
`define REG_RECORD_SLOT 6'h26
`define REG_OPCODE      6'h27
`define CTRL_WAIT_BIT   0
// pointer table reset image: entry n = base + n * step, low byte first
`define TAB_BASE        16'h0100
`define TAB_STEP        16'h0010
// command byte
`define CMD_STRING      4'h1
// command string byte offsets
`define STR_FN          3'h0
`define STR_STATUS      3'h1
`define STR_TRACK       3'h2
`define STR_RECORD_SLOT 3'h3
`define STR_PTR_LO      3'h4
`define STR_PTR_HI      3'h5
`define FN_PHYS_BIT     7
// status byte values, all nonzero
`define STAT_OK         8'h01
`define STAT_ERR        8'h02
`define STAT_NOTRDY     8'h03
`define STAT_BADPARAM   8'h04
// counts and ranges
`define RETRY_MAX       4'ha
`define SLOT_MIN        8'h01
`define SLOT_MAX        8'h1a
`define OP_MAX          4'h5
`define OP_READ_ALL     4'h5
`define HEAD_RAISED     2'h0
`define HEAD_LOWERED    2'h1
`define HEAD_LIFT_PEND  2'h2
`endif

// ---- hdl/fdc_host_pkg.sv ----
// types of the floppy host command block
// needs no include; nothing from the map header is used here
package fdc_host_pkg;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_FETCH  = 6'h02,
    ST_CHECK  = 6'h04,
    ST_EXEC   = 6'h08,
    ST_STATUS = 6'h10,
    ST_SPARE  = 6'h20
  } fsm_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dma_req_t;

  typedef struct packed {
    logic start;
    logic [3:0] op;
    logic [7:0] track;
    logic [7:0] sector;
    logic [15:0] xfer_ptr;
  } exec_cmd_t;

  typedef struct packed {
    fsm_t fsm;
    logic pend;
    logic [7:0] cmd;
    logic irq;
    logic [31:0][7:0] tab;
    logic [15:0] str_ptr;
    logic [15:0] stat_ptr;
    logic [2:0] idx;
    logic [7:0] fn;
    logic [7:0] op_code;
    logic [7:0] logical_track;
    logic [7:0] physical_track;
    logic [7:0] current_record_slot;
    logic [3:0] retry;
    logic [1:0] head;
    logic wait_flag;
    logic [7:0] trk_skip;
    logic [7:0] status;
    dma_req_t dma;
    exec_cmd_t exec;
    logic [7:0] rdata;
    logic rdy_s1;
    logic rdy_s2;
    logic rdy_d;
    logic idx_s1;
    logic idx_s2;
    logic idx_d;
    logic restore;
  } state_t;
endpackage

// ---- hdl/floppy_host_command_interface.sv ----
// host command interface of a floppy disk controller: port command, string fetch by dma,
// status write-back, interrupt request and internal track/sector/head bookkeeping
// assumes host port, dma and disk engine strobes on sys_clk_i; drive ready and index are pins
//
// What this block does
// - host writes one command byte to the jumpered port; controller takes it.
// - host is held in wait until the idle machine takes the captured command.
// - single-byte command completes only by the controller being ready again.
// - command strings are read, and status written, by direct memory access.
// - interrupt request rises when the nonzero status byte is written.
// - every accepted port write clears the pending interrupt request.
// - unknown command bytes do nothing except the acceptance side effect.
// - status sits in string byte two; pointer kept as two bytes.
// - 32-byte string pointer table with defaults, rewritable by the host.
// - two-byte transfer pointer for the current data transfer.
// - errors are retried up to ten times before an error status.
// - drive dropping ready with wait flag zero is fatal, no retry.
// - head state 0 raised, 1 lowered, 2 lift pending one revolution.
// - sector is 1 to 26; holds start delay during read-all.
// - operation code 0 to 5 in upper nibble, physical flag removed.
// - physical and logical track kept separately, may differ.
// - drives returning to ready get head position re-established internally.
// - reported hardware errors are final after internal recovery.
// - interrupt output is a single line, irq_o, with polarity selectable.
`timescale 1ns/10ps
`default_nettype none
`include "fdc_host_map.svh"
module floppy_host_command_interface
  import fdc_host_pkg::*;
#(
  parameter logic [7:0] PORT_ADDR = 8'hfd,
  parameter bit IRQ_INVERT = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_data_i,
  output logic port_wait_o,
  output logic port_ready_o,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output dma_req_t dma_o,
  input wire logic dma_ack_i,
  input wire logic [7:0] dma_rdata_i,
  output exec_cmd_t exec_o,
  input wire logic exec_done_i,
  input wire logic exec_err_i,
  input wire logic drive_ready_i,
  input wire logic index_i,
  output logic restore_o,
  output logic [1:0] head_state_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // pointer table reset image
  // ----------------------------------------------------------------
  function automatic logic [31:0][7:0] tab_default();
    logic [31:0][7:0] t;
    logic [15:0] p;
    t = '0;
    for (int i = 0; i < 16; i++) begin
      p = 16'(`TAB_BASE + 16'(i) * `TAB_STEP);
      t[2*i] = p[7:0];
      t[2*i+1] = p[15:8];
    end
    return t;
  endfunction
  // worked out once here so the asynchronous reset branch only loads a constant
  localparam logic [31:0][7:0] TAB_INIT = tab_default();

  state_t s_r, s_nxt;
  logic accept;
  logic ready_rise;
  logic index_rise;
  logic [15:0] tab_ptr;

  assign accept = (s_r.fsm == ST_IDLE) && s_r.pend;
  assign ready_rise = s_r.rdy_s2 && !s_r.rdy_d;
  assign index_rise = s_r.idx_s2 && !s_r.idx_d;
  assign tab_ptr = {s_r.tab[{s_r.cmd[3:0], 1'b1}], s_r.tab[{s_r.cmd[3:0], 1'b0}]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.exec.start = 1'b0;
    s_nxt.restore = 1'b0;
    s_nxt.rdata = 8'h00;
    // pins pass two flops; only the second and its one-cycle delayed copy are looked at
    s_nxt.rdy_s1 = drive_ready_i;
    s_nxt.rdy_s2 = s_r.rdy_s1;
    s_nxt.rdy_d = s_r.rdy_s2;
    s_nxt.idx_s1 = index_i;
    s_nxt.idx_s2 = s_r.idx_s1;
    s_nxt.idx_d = s_r.idx_s2;

    // host port write: captured at once, host waits until the idle machine takes it
    if (io_wr_i && io_addr_i == PORT_ADDR && !s_r.pend) begin
      s_nxt.pend = 1'b1;
      s_nxt.cmd = io_data_i;
    end

    // register port
    if (reg_wr_i) begin
      if (reg_addr_i <= `REG_TAB_LAST) begin
        s_nxt.tab[reg_addr_i[4:0]] = reg_wdata_i;
      end else if (reg_addr_i == `REG_CTRL) begin
        s_nxt.wait_flag = reg_wdata_i[`CTRL_WAIT_BIT];
      end else if (reg_addr_i == `REG_TRK_SKIP) begin
        s_nxt.trk_skip = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i <= `REG_TAB_LAST) begin
        s_nxt.rdata = s_r.tab[reg_addr_i[4:0]];
      end else begin
        case (reg_addr_i)
          `REG_CTRL: s_nxt.rdata = {7'h00, s_r.wait_flag};
          `REG_TRK_SKIP: s_nxt.rdata = s_r.trk_skip;
          `REG_STATE: s_nxt.rdata = {s_r.fsm[4:0], s_r.irq, s_r.head};
          `REG_RETRY: s_nxt.rdata = {4'h0, s_r.retry};
          `REG_PHYSICAL_TRACK: s_nxt.rdata = s_r.physical_track;
          `REG_LOGICAL_TRACK: s_nxt.rdata = s_r.logical_track;
          `REG_RECORD_SLOT: s_nxt.rdata = s_r.current_record_slot;
          `REG_OPCODE: s_nxt.rdata = s_r.op_code;
          default: s_nxt.rdata = 8'h00;
        endcase
      end
    end

    // head lifted one revolution (next index pulse) after the operation ends
    if (s_r.head == `HEAD_LIFT_PEND && index_rise) begin
      s_nxt.head = `HEAD_RAISED;
    end

    // a drive coming back on line is walked to track 0 by the disk engine
    if (ready_rise) begin
      s_nxt.restore = 1'b1;
      s_nxt.physical_track = 8'h00;
    end

    case (s_r.fsm)
      ST_IDLE: begin
        if (accept) begin
          s_nxt.pend = 1'b0;
          s_nxt.irq = 1'b0;
          if (s_r.cmd[7:4] == `CMD_STRING) begin
            s_nxt.str_ptr = tab_ptr;
            s_nxt.stat_ptr = tab_ptr + 16'(`STR_STATUS);
            s_nxt.idx = `STR_FN;
            s_nxt.retry = 4'h0;
            s_nxt.dma.req = 1'b1;
            s_nxt.dma.we = 1'b0;
            s_nxt.dma.addr = tab_ptr;
            s_nxt.fsm = ST_FETCH;
          end
          // any other byte is a no-op; the machine stays ready for the next one
        end
      end
      ST_FETCH: begin
        if (dma_ack_i) begin
          case (s_r.idx)
            `STR_FN: s_nxt.fn = dma_rdata_i;
            `STR_TRACK: s_nxt.logical_track = dma_rdata_i;
            `STR_RECORD_SLOT: s_nxt.current_record_slot = dma_rdata_i;
            `STR_PTR_LO: s_nxt.exec.xfer_ptr[7:0] = dma_rdata_i;
            `STR_PTR_HI: s_nxt.exec.xfer_ptr[15:8] = dma_rdata_i;
            default: s_nxt.fn = s_r.fn;
          endcase
          if (s_r.idx == `STR_PTR_HI) begin
            s_nxt.dma.req = 1'b0;
            s_nxt.fsm = ST_CHECK;
          end else begin
            // status byte is left alone on the way in
            s_nxt.idx = (s_r.idx == `STR_FN) ? `STR_TRACK : 3'(s_r.idx + 3'h1);
            s_nxt.dma.addr = s_r.str_ptr + 16'((s_r.idx == `STR_FN) ? `STR_TRACK : 3'(s_r.idx + 3'h1));
          end
        end
      end
      ST_CHECK: begin
        s_nxt.op_code = {s_r.fn[3:0], 4'h0};
        // physical flag picks the raw track, else the skip offset maps past bad tracks
        s_nxt.physical_track = s_r.fn[`FN_PHYS_BIT] ? s_r.logical_track : 8'(s_r.logical_track + s_r.trk_skip);
        if (s_r.fn[3:0] > `OP_MAX ||
            (s_r.fn[3:0] != `OP_READ_ALL &&
             (s_r.current_record_slot < `SLOT_MIN || s_r.current_record_slot > `SLOT_MAX))) begin
          s_nxt.status = `STAT_BADPARAM;
          s_nxt.fsm = ST_STATUS;
        end else begin
          s_nxt.exec.start = 1'b1;
          s_nxt.exec.op = s_r.fn[3:0];
          s_nxt.exec.track = s_r.fn[`FN_PHYS_BIT] ? s_r.logical_track : 8'(s_r.logical_track + s_r.trk_skip);
          s_nxt.exec.sector = s_r.current_record_slot;
          s_nxt.head = `HEAD_LOWERED;
          s_nxt.fsm = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!s_r.rdy_s2) begin
          // with the flag set the operation just waits for the drive to come back
          if (!s_r.wait_flag) begin
            s_nxt.status = `STAT_NOTRDY;
            s_nxt.head = `HEAD_LIFT_PEND;
            s_nxt.fsm = ST_STATUS;
          end
        end else if (exec_err_i) begin
          if (s_r.retry == `RETRY_MAX) begin
            s_nxt.status = `STAT_ERR;
            s_nxt.head = `HEAD_LIFT_PEND;
            s_nxt.fsm = ST_STATUS;
          end else begin
            s_nxt.retry = 4'(s_r.retry + 4'h1);
            s_nxt.exec.start = 1'b1;
          end
        end else if (exec_done_i) begin
          s_nxt.status = `STAT_OK;
          s_nxt.head = `HEAD_LIFT_PEND;
          s_nxt.fsm = ST_STATUS;
        end
      end
      ST_STATUS: begin
        s_nxt.dma.req = 1'b1;
        s_nxt.dma.we = 1'b1;
        s_nxt.dma.addr = s_r.stat_ptr;
        s_nxt.dma.wdata = s_r.status;
        if (s_r.dma.req && s_r.dma.we && dma_ack_i) begin
          s_nxt.dma.req = 1'b0;
          s_nxt.dma.we = 1'b0;
          s_nxt.irq = 1'b1;
          s_nxt.fsm = ST_IDLE;
        end
      end
      default: begin
        s_nxt.fsm = ST_IDLE;
        s_nxt.dma.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.tab <= TAB_INIT;
      s_r.head <= `HEAD_RAISED;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign port_wait_o = s_r.pend;
  assign port_ready_o = (s_r.fsm == ST_IDLE) && !s_r.pend;
  assign reg_rdata_o = s_r.rdata;
  assign dma_o = s_r.dma;
  assign exec_o = s_r.exec;
  assign restore_o = s_r.restore;
  assign head_state_o = s_r.head;
  // polarity strap stands in for the board's inverting jumper
  assign irq_o = s_r.irq ^ IRQ_INVERT;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_wait_until_taken: assert property (
    s_r.pend && s_r.fsm != ST_IDLE |=> port_wait_o)
    else $error("host released before command taken");
  a_accept_clears: assert property (
    accept |=> !s_r.irq && !port_wait_o)
    else $error("accept did not clear irq and wait");
  a_irq_on_status: assert property (
    s_r.fsm == ST_STATUS && s_r.dma.we && dma_ack_i |=> s_r.irq && s_r.fsm == ST_IDLE)
    else $error("irq not raised with status write");
  a_status_nonzero: assert property (
    s_r.dma.req && s_r.dma.we |-> s_r.dma.wdata != 8'h00 && s_r.dma.addr == s_r.str_ptr + 16'h0001)
    else $error("status write wrong value or address");
  a_nop_stays_idle: assert property (
    accept && s_r.cmd[7:4] != `CMD_STRING |=> s_r.fsm == ST_IDLE && !s_r.dma.req)
    else $error("unknown command started work");
  a_retry_bound: assert property (
    s_r.fsm == ST_EXEC && s_r.rdy_s2 && exec_err_i && s_r.retry == `RETRY_MAX
    |=> s_r.fsm == ST_STATUS && s_r.status == `STAT_ERR)
    else $error("retry limit not honoured");
  a_notready_fatal: assert property (
    s_r.fsm == ST_EXEC && !s_r.rdy_s2 && !s_r.wait_flag
    |=> s_r.status == `STAT_NOTRDY && s_r.retry == $past(s_r.retry) && !s_r.exec.start)
    else $error("not ready was retried");
  a_head_code: assert property (
    s_r.fsm == ST_EXEC |-> s_r.head == `HEAD_LOWERED)
    else $error("head not lowered during operation");
  a_sector_range: assert property (
    s_r.exec.start && s_r.exec.op != `OP_READ_ALL
    |-> s_r.exec.sector >= `SLOT_MIN && s_r.exec.sector <= `SLOT_MAX)
    else $error("sector out of range issued");
  a_restore_ready: assert property (
    ready_rise |=> restore_o && s_r.physical_track == 8'h00)
    else $error("no restore on drive return");

  c_string_ok: cover property (s_r.fsm == ST_STATUS && s_r.status == `STAT_OK && dma_ack_i);
  c_retry_then_ok: cover property (s_r.retry != 4'h0 && s_r.status == `STAT_OK && s_r.irq);
  c_fatal: cover property (s_r.fsm == ST_STATUS && s_r.status == `STAT_NOTRDY);
  c_nop_clear: cover property (accept && s_r.irq && s_r.cmd[7:4] != `CMD_STRING);
  c_drive_stall: cover property (s_r.fsm == ST_EXEC && !s_r.rdy_s2 && s_r.wait_flag);

  // a string entering its check cycle may lower the head again, so that cycle is left out
  a_port_capture: assert property (
    io_wr_i && io_addr_i == PORT_ADDR && !s_r.pend |=> port_wait_o && s_r.cmd == $past(io_data_i))
    else $error("port write not captured");
  a_nop_ready: assert property (
    accept && s_r.cmd[7:4] != `CMD_STRING |=> port_ready_o)
    else $error("no-op did not return to ready");
  a_status_skipped: assert property (
    s_r.fsm == ST_FETCH && dma_ack_i && s_r.idx == `STR_FN |=> s_r.dma.addr == s_r.str_ptr + 16'h0002)
    else $error("fetch did not skip the status byte");
  a_table_write: assert property (
    reg_wr_i && reg_addr_i <= `REG_TAB_LAST |=> s_r.tab[$past(reg_addr_i)] == $past(reg_wdata_i))
    else $error("table byte not written");
  a_xfer_ptr_load: assert property (
    s_r.fsm == ST_FETCH && dma_ack_i && s_r.idx == `STR_PTR_HI |=> exec_o.xfer_ptr[15:8] == $past(dma_rdata_i))
    else $error("transfer pointer not loaded");
  a_retry_step: assert property (
    s_r.fsm == ST_EXEC && s_r.rdy_s2 && exec_err_i && s_r.retry != `RETRY_MAX
    |=> s_r.retry == 4'($past(s_r.retry) + 4'h1) && exec_o.start)
    else $error("retry not counted and restarted");
  a_head_lift: assert property (
    s_r.head == `HEAD_LIFT_PEND && index_rise && s_r.fsm != ST_CHECK |=> head_state_o == `HEAD_RAISED)
    else $error("head not lifted on the next revolution");
  a_op_issued: assert property (
    exec_o.start |-> exec_o.op <= `OP_MAX && s_r.op_code[3:0] == 4'h0 && s_r.op_code[7:4] == exec_o.op)
    else $error("operation code out of range or misplaced");

endmodule
`default_nettype wire
